// File: rxf_xlat_resp.sv
// Contract
// [R1] interrupt window request completes with R=0 W=1 U=1 S=0.
// [R2] missing translation, or neither read nor write, gives zero permissions.
// [R3] second-level address above min of max and adjusted width: zero.
// [R4] PASID request with bits 63:48 not equal bit 47: zero.
// [R5] second-level entry with read and write clear ends walk: zero.
// [R6] AND of read and write bits across levels both zero: zero.
// [R7] PASID-table entry not present gives zero-permission completion.
// [R8] first-level entry not present ends walk: zero permissions.
// [R9] recoverable cases never flag non-recoverable faults; completion succeeds.
// [R10] granted translation reports no further violations; success with attrs.
// [R11] endpoint discards its faulting cached translation itself.
// [R12] reported recoverable page fault invalidates own translation caches.
// [R13] endpoint reports recoverable faults via page-request message.
// [R14] endpoint may replay operation after fresh translation request.
// [R15] interrupt window checked before any table walk.
module rxf_xlat_resp (
   // clock and reset
   input  wire logic                     I_CLK_SYS,
   input  wire logic                     I_RESET,
   // translation request
   input  wire logic                     I_REQ_VALID,
   input  wire rxf_pkg::rxf_req_t        I_REQ,
   output logic                          O_REQ_READY,
   // walker entries
   input  wire logic                     I_ENT_VALID,
   input  wire rxf_pkg::rxf_ent_t        I_ENT,
   output logic                          O_WALK_START,
   // completion
   output logic                          O_CPL_VALID,
   output rxf_pkg::rxf_cpl_t             O_CPL,
   input  wire logic                     I_CPL_READY,
   // fault handling
   output logic                          O_NR_FAULT,
   input  wire logic                     I_PGFAULT_RPT,
   output logic                          O_INVAL,
   // axi4-lite slave
   input  wire logic [rxf_pkg::AXI_AW-1:0] S_AXI_AWADDR,
   input  wire logic                     S_AXI_AWVALID,
   output logic                          S_AXI_AWREADY,
   input  wire logic [rxf_pkg::AXI_DW-1:0] S_AXI_WDATA,
   input  wire logic [3:0]               S_AXI_WSTRB,
   input  wire logic                     S_AXI_WVALID,
   output logic                          S_AXI_WREADY,
   output logic [1:0]                    S_AXI_BRESP,
   output logic                          S_AXI_BVALID,
   input  wire logic                     S_AXI_BREADY,
   input  wire logic [rxf_pkg::AXI_AW-1:0] S_AXI_ARADDR,
   input  wire logic                     S_AXI_ARVALID,
   output logic                          S_AXI_ARREADY,
   output logic [rxf_pkg::AXI_DW-1:0]    S_AXI_RDATA,
   output logic [1:0]                    S_AXI_RRESP,
   output logic                          S_AXI_RVALID,
   input  wire logic                     S_AXI_RREADY
);
   import rxf_pkg::*;

   rxf_state_t        state_reg;
   rxf_req_t          req_reg;
   logic              rd_and_reg;
   logic              wr_and_reg;
   logic              walk_sl_reg;
   logic [6:0]        max_guest_addr_width_reg;
   logic              enable_reg;
   logic [15:0]       zero_cnt_reg;
   logic [15:0]       inv_cnt_reg;
   logic              last_zero_reg;
   rxf_cpl_t          cpl_next;

   // ---------------- request checks
   logic       is_msi;
   logic       non_canon;
   logic [6:0] lim_w;
   logic       over_w;
   logic [ADDR_W-1:0] lim_mask;

   assign is_msi = (I_REQ.addr[MSI_HI:MSI_LO] == MSI_TAG) &&
                   (I_REQ.addr[ADDR_W-1:MSI_HI+1] == '0);
   assign non_canon = I_REQ.has_pasid &&
      (I_REQ.addr[CANON_HI:CANON_LO] !=
       {CANON_W{I_REQ.addr[CANON_BIT]}}); // [R4]
   assign lim_w = (max_guest_addr_width_reg < I_REQ.adj_width) ? max_guest_addr_width_reg : I_REQ.adj_width;
   // address above 2^lim_w - 1 has a set bit at or above lim_w
   assign lim_mask = (lim_w >= 7'(ADDR_W)) ? '0 : ({ADDR_W{1'b1}} << lim_w);
   assign over_w = |(I_REQ.addr & lim_mask);

   logic take_req;
   assign take_req = (state_reg == ST_IDLE) && I_REQ_VALID && enable_reg;

   // entry verdicts
   logic ent_fail;
   logic rd_and_n;
   logic wr_and_n;
   assign rd_and_n = rd_and_reg & I_ENT.rd;
   assign wr_and_n = wr_and_reg & I_ENT.wr;
   assign ent_fail = I_ENT.first_level ? !I_ENT.present // [R7] [R8]
                                       : (!I_ENT.rd && !I_ENT.wr); // [R2] [R5]

   // ---------------- state machine
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (take_req) begin
                  // window and address checks end without a walk
                  if (is_msi || non_canon || over_w) begin // [R15]
                     state_reg <= ST_CPL;
                  end else begin
                     state_reg <= ST_WALK;
                  end
               end
            end
            ST_WALK: begin
               if (I_ENT_VALID && (ent_fail || I_ENT.last)) begin
                  state_reg <= ST_CPL;
               end
            end
            ST_CPL: begin
               if (I_CPL_READY) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         req_reg     <= '0;
         rd_and_reg  <= 1'b0;
         wr_and_reg  <= 1'b0;
         walk_sl_reg <= 1'b0;
      end else if (take_req) begin
         req_reg     <= I_REQ;
         rd_and_reg  <= 1'b1;
         wr_and_reg  <= 1'b1;
         walk_sl_reg <= 1'b0;
      end else if (state_reg == ST_WALK && I_ENT_VALID) begin
         rd_and_reg  <= rd_and_n; // [R6]
         wr_and_reg  <= wr_and_n; // [R6]
         walk_sl_reg <= walk_sl_reg | !I_ENT.first_level;
      end
   end

   // ---------------- completion builder
   always_comb begin
      cpl_next      = '0;
      cpl_next.id   = I_REQ.id;
      cpl_next.ok   = 1'b1; // [R9]
      if (state_reg == ST_IDLE) begin
         if (is_msi) begin
            cpl_next.wr   = 1'b1; // [R1]
            cpl_next.untr = 1'b1; // [R1]
         end
         // non-canonical and width cases keep all-zero permissions [R3] [R4]
      end else begin
         cpl_next.id = req_reg.id;
         if (!ent_fail) begin
            // granted: no privilege or execute violation reported [R10]
            cpl_next.rd  = rd_and_n;
            cpl_next.wr  = wr_and_n;
            cpl_next.sup = 1'b0;
         end
      end
   end

   logic load_cpl;
   assign load_cpl =
      (take_req && (is_msi || non_canon || over_w)) ||
      (state_reg == ST_WALK && I_ENT_VALID && (ent_fail || I_ENT.last));

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         O_CPL_VALID <= 1'b0;
         O_CPL       <= '0;
      end else if (load_cpl) begin
         O_CPL_VALID <= 1'b1;
         O_CPL       <= cpl_next;
      end else if (O_CPL_VALID && I_CPL_READY) begin
         O_CPL_VALID <= 1'b0;
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         O_REQ_READY  <= 1'b0;
         O_WALK_START <= 1'b0;
         O_NR_FAULT   <= 1'b0;
      end else begin
         O_REQ_READY  <= (state_reg == ST_IDLE) && enable_reg && !take_req;
         O_WALK_START <= take_req && !(is_msi || non_canon || over_w);
         O_NR_FAULT   <= 1'b0; // [R9]
      end
   end

   // caches depend on the endpoint dropping its own copy [R11]
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         O_INVAL     <= 1'b0;
         inv_cnt_reg <= '0;
      end else begin
         O_INVAL <= I_PGFAULT_RPT; // [R12]
         if (I_PGFAULT_RPT) begin
            inv_cnt_reg <= inv_cnt_reg + 16'h0001;
         end
      end
   end

   logic zero_cpl;
   assign zero_cpl = !cpl_next.rd && !cpl_next.wr;
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         zero_cnt_reg  <= '0;
         last_zero_reg <= 1'b0;
      end else if (load_cpl) begin
         last_zero_reg <= zero_cpl;
         if (zero_cpl) begin
            zero_cnt_reg <= zero_cnt_reg + 16'h0001;
         end
      end
   end

   // ---------------- axi4-lite slave
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [AXI_AW-1:0] awaddr_reg;
   logic [AXI_DW-1:0] wdata_reg;
   logic do_wr;
   assign do_wr = aw_hold_reg && w_hold_reg && !S_AXI_BVALID;

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         aw_hold_reg   <= 1'b0;
         w_hold_reg    <= 1'b0;
         awaddr_reg    <= '0;
         wdata_reg     <= '0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= RESP_OK;
      end else begin
         S_AXI_AWREADY <= !aw_hold_reg && !S_AXI_AWREADY;
         S_AXI_WREADY  <= !w_hold_reg && !S_AXI_WREADY;
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= S_AXI_WDATA;
         end
         if (do_wr) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (awaddr_reg == A_CTRL) ? RESP_OK : RESP_ERR;
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // ctrl: bit0 enable, bits 14:8 max guest width; full-word writes only
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         enable_reg <= 1'b1;
         max_guest_addr_width_reg   <= MAX_GUEST_ADDR_WIDTH_RST;
      end else if (do_wr && awaddr_reg == A_CTRL) begin
         enable_reg <= wdata_reg[0];
         max_guest_addr_width_reg   <= wdata_reg[14:8];
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= '0;
         S_AXI_RRESP   <= RESP_OK;
      end else begin
         S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= RESP_OK;
            case (S_AXI_ARADDR)
               A_CTRL:   S_AXI_RDATA <= {17'h0, max_guest_addr_width_reg, 7'h0, enable_reg};
               A_STAT:   S_AXI_RDATA <= {28'h0, last_zero_reg,
                                         O_CPL_VALID, state_reg};
               A_RCNT:   S_AXI_RDATA <= {16'h0, zero_cnt_reg};
               A_INVCNT: S_AXI_RDATA <= {16'h0, inv_cnt_reg};
               default: begin
                  S_AXI_RDATA <= '0;
                  S_AXI_RRESP <= RESP_ERR;
               end
            endcase
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // ---------------- assertions
   property p_msi_resp;
      @(posedge I_CLK_SYS) disable iff (I_RESET)
      (take_req && is_msi) |=> O_CPL_VALID && !O_CPL.rd && O_CPL.wr &&
         O_CPL.untr && !O_CPL.sup && O_CPL.ok;
   endproperty
   a_msi_resp: assert property (p_msi_resp) // [R1]
      else $error("interrupt window completion wrong");

   property p_msi_nowalk;
      @(posedge I_CLK_SYS) disable iff (I_RESET)
      (take_req && is_msi) |=> !O_WALK_START && state_reg == ST_CPL;
   endproperty
   a_msi_nowalk: assert property (p_msi_nowalk) // [R15]
      else $error("interrupt window started a walk");

   property p_canon;
      @(posedge I_CLK_SYS) disable iff (I_RESET)
      (take_req && !is_msi && non_canon) |=> O_CPL_VALID &&
         !O_CPL.rd && !O_CPL.wr && !O_CPL.untr;
   endproperty
   a_canon: assert property (p_canon) // [R4]
      else $error("non-canonical address granted");

   property p_width;
      @(posedge I_CLK_SYS) disable iff (I_RESET)
      (take_req && !is_msi && over_w) |=> O_CPL_VALID &&
         !O_CPL.rd && !O_CPL.wr;
   endproperty
   a_width: assert property (p_width) // [R3]
      else $error("over-width address granted");

   property p_entfail;
      @(posedge I_CLK_SYS) disable iff (I_RESET)
      (state_reg == ST_WALK && I_ENT_VALID && ent_fail) |=>
         O_CPL_VALID && !O_CPL.rd && !O_CPL.wr && state_reg == ST_CPL;
   endproperty
   a_entfail: assert property (p_entfail) // [R5]
      else $error("failed entry did not end walk with zero grant");

   property p_fl_np;
      @(posedge I_CLK_SYS) disable iff (I_RESET)
      (state_reg == ST_WALK && I_ENT_VALID && I_ENT.first_level &&
       !I_ENT.present) |=> O_CPL_VALID && O_CPL.ok && !O_CPL.rd;
   endproperty
   a_fl_np: assert property (p_fl_np) // [R8]
      else $error("not-present entry granted");

   property p_and;
      @(posedge I_CLK_SYS) disable iff (I_RESET)
      (state_reg == ST_WALK && I_ENT_VALID && I_ENT.last && !ent_fail) |=>
         O_CPL.rd == $past(rd_and_n) && O_CPL.wr == $past(wr_and_n);
   endproperty
   a_and: assert property (p_and) // [R6]
      else $error("permission AND across levels wrong");

   property p_nofault;
      @(posedge I_CLK_SYS) disable iff (I_RESET)
      O_CPL_VALID |-> !O_NR_FAULT && O_CPL.ok;
   endproperty
   a_nofault: assert property (p_nofault) // [R9]
      else $error("recoverable case flagged as fault");

   property p_inval;
      @(posedge I_CLK_SYS) disable iff (I_RESET)
      I_PGFAULT_RPT |=> O_INVAL;
   endproperty
   a_inval: assert property (p_inval) // [R12]
      else $error("page fault report did not invalidate");

   property p_grant;
      @(posedge I_CLK_SYS) disable iff (I_RESET)
      (load_cpl && state_reg == ST_WALK && (rd_and_n || wr_and_n) &&
       !ent_fail) |=> !O_CPL.sup && O_CPL.ok; // [R10]
   endproperty
   a_grant: assert property (p_grant) // [R10]
      else $error("granted translation carried violation");

   c_msi: cover property (@(posedge I_CLK_SYS) take_req && is_msi);
   c_walk_ok: cover property (@(posedge I_CLK_SYS)
      O_CPL_VALID && O_CPL.rd && O_CPL.wr);
   c_zero: cover property (@(posedge I_CLK_SYS)
      state_reg == ST_WALK && I_ENT_VALID && ent_fail);
   c_inval: cover property (@(posedge I_CLK_SYS) O_INVAL);
endmodule

// File: rxf_pkg.sv
package rxf_pkg;
   localparam int ADDR_W      = 64;
   localparam int ID_W        = 8;
   localparam int MAX_LVL     = 4;
   localparam int LVL_W       = 3;
   localparam int AXI_AW      = 8;
   localparam int AXI_DW      = 32;
   // interrupt window: address bits 31:20 equal 12'hFEE and bits 63:32 are zero
   localparam logic [11:0] MSI_TAG  = 12'hFEE;
   localparam int MSI_HI      = 31;
   localparam int MSI_LO      = 20;
   localparam int CANON_HI    = 63;
   localparam int CANON_LO    = 48;
   localparam int CANON_BIT   = 47;
   localparam int CANON_W     = CANON_HI - CANON_LO + 1;
   // register byte addresses
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_STAT   = 8'h04;
   localparam logic [7:0] A_RCNT   = 8'h08;
   localparam logic [7:0] A_INVCNT = 8'h0C;
   localparam logic [6:0] MAX_GUEST_ADDR_WIDTH_RST = 7'h30;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [ID_W-1:0]   id;
      logic              has_pasid;
      logic [6:0]        adj_width;
   } rxf_req_t;

   // one paging-structure entry handed over by the walker
   typedef struct packed {
      logic            first_level;
      logic            present;
      logic            rd;
      logic            wr;
      logic            last;
      logic            pasid_entry;
   } rxf_ent_t;

   typedef struct packed {
      logic [ID_W-1:0] id;
      logic            rd;
      logic            wr;
      logic            untr;
      logic            sup;
      logic            ok;
   } rxf_cpl_t;

   typedef enum logic [1:0] {
      ST_IDLE, ST_WALK, ST_CPL
   } rxf_state_t;
endpackage

// File: rxf_ep_model.sv
module rxf_ep_model (
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // bench side
   input  wire logic              i_go,
   input  wire rxf_pkg::rxf_req_t i_req,
   input  wire logic [3:0]        i_stall,
   output logic                   o_done = 1'h0,
   output rxf_pkg::rxf_cpl_t      o_cpl = '0,
   // unit side
   output logic                   o_req_valid = 1'h0,
   output rxf_pkg::rxf_req_t      o_req = '0,
   input  wire logic              i_taken,
   input  wire logic              i_cpl_valid,
   input  wire rxf_pkg::rxf_cpl_t i_cpl,
   output logic                   o_cpl_ready = 1'h0,
   output logic                   o_pgfault = 1'h0
);
   import rxf_pkg::*;
   logic [3:0] wait_reg;
   logic       cached_reg;

   // held until a walk start or completion shows it was taken
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_req_valid <= 1'h0;
      end else if (i_go) begin
         o_req_valid <= 1'h1;
         o_req       <= i_req;
      end else if (o_req_valid && i_taken) begin
         o_req_valid <= 1'h0;
         o_req       <= ~o_req;
      end
   end

   // ready only after the chosen stall, like a busy cache
   always @(posedge i_clk) begin
      o_done    <= 1'h0;
      o_pgfault <= 1'h0;
      if (i_rst) begin
         o_cpl_ready <= 1'h0;
         wait_reg    <= 4'h0;
         cached_reg  <= 1'h0;
      end else if (i_cpl_valid && o_cpl_ready) begin
         o_cpl_ready <= 1'h0;
         wait_reg    <= 4'h0;
         o_done      <= 1'h1;
         o_cpl       <= i_cpl;
         // no rights: access faults, drop entry and ask for the page
         cached_reg  <= i_cpl.rd | i_cpl.wr;
         o_pgfault   <= ~(i_cpl.rd | i_cpl.wr);
      end else if (i_cpl_valid) begin
         o_cpl_ready <= (wait_reg == i_stall);
         wait_reg    <= wait_reg + 4'h1;
      end
   end
endmodule

// File: test_rxf_xlat_resp.sv
module test_rxf_xlat_resp;
   timeunit 1ns;
   timeprecision 100ps;
   import rxf_pkg::*;

   typedef struct packed {
      rxf_req_t       req;
      logic [1:0]     n_ent;
      rxf_ent_t [2:0] ent;
      logic [3:0]     perm;
   } rxf_row_t;

   logic        I_CLK_SYS, I_RESET, I_REQ_VALID, O_REQ_READY, I_ENT_VALID;
   logic        O_WALK_START, O_CPL_VALID, I_CPL_READY, O_NR_FAULT;
   logic        I_PGFAULT_RPT, O_INVAL, go, ep_done, live, inval_exp;
   rxf_req_t    I_REQ, go_req;
   rxf_ent_t    I_ENT;
   rxf_cpl_t    O_CPL, ep_cpl;
   logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd_data;
   logic [3:0]  S_AXI_WSTRB, stall;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, resp;
   logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
   logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
   logic        S_AXI_RVALID, S_AXI_RREADY;
   rxf_row_t    rows [12];
   int          fails = 0, checked = 0, zeros = 0, i;

   rxf_xlat_resp dut (.I_CLK_SYS, .I_RESET, .I_REQ_VALID, .I_REQ,
      .O_REQ_READY, .I_ENT_VALID, .I_ENT, .O_WALK_START, .O_CPL_VALID,
      .O_CPL, .I_CPL_READY, .O_NR_FAULT, .I_PGFAULT_RPT, .O_INVAL,
      .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
      .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
      .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
      .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
      .S_AXI_RREADY);
   rxf_ep_model ep (.i_clk(I_CLK_SYS), .i_rst(I_RESET), .i_go(go),
      .i_req(go_req), .i_stall(stall), .o_done(ep_done), .o_cpl(ep_cpl),
      .o_req_valid(I_REQ_VALID), .o_req(I_REQ),
      .i_taken(O_WALK_START | O_CPL_VALID), .i_cpl_valid(O_CPL_VALID),
      .i_cpl(O_CPL), .o_cpl_ready(I_CPL_READY), .o_pgfault(I_PGFAULT_RPT));

   always #20 I_CLK_SYS = ~I_CLK_SYS;

   task automatic conclude();
      if (fails == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cmp_w(input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic cmp_cpl(input rxf_cpl_t e, input rxf_cpl_t g,
                          input logic [12:0] m);
      checked++;
      if ((g & m) !== (e & m)) begin
         fails++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic tmo(input int n);
      if (n >= 60) begin
         fails++;
         conclude();
      end
   endtask

   function automatic rxf_row_t mk(input logic [63:0] a, input logic p,
      input logic [6:0] w, input logic [1:0] n, input logic [17:0] e,
      input logic [3:0] pm);
      mk = {a, 8'h00, p, w, n, e, pm};
   endfunction

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge I_CLK_SYS);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA  <= d;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
      for (n = 0; n < 60; n++) begin
         @(posedge I_CLK_SYS);
         if (S_AXI_AWREADY === 1'h1) S_AXI_AWVALID <= 1'h0;
         if (S_AXI_WREADY === 1'h1) S_AXI_WVALID <= 1'h0;
         if (S_AXI_BVALID === 1'h1) break;
      end
      resp = S_AXI_BRESP;
      S_AXI_BREADY <= 1'h0;
      tmo(n);
   endtask

   // data is only compared when an OKAY response is expected
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
      int n;
      @(posedge I_CLK_SYS);
      S_AXI_ARADDR <= a;
      {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
      for (n = 0; n < 60; n++) begin
         @(posedge I_CLK_SYS);
         if (S_AXI_ARREADY === 1'h1) S_AXI_ARVALID <= 1'h0;
         if (S_AXI_RVALID === 1'h1) break;
      end
      rd_data = S_AXI_RDATA;
      resp = S_AXI_RRESP;
      S_AXI_RREADY <= 1'h0;
      tmo(n);
      cmp_w(32'(resp), 32'(er));
      if (er === RESP_OK) cmp_w(rd_data, ed);
   endtask

   // entries go back to back as soon as the walk starts
   task automatic run(input rxf_row_t w, input logic [7:0] id,
                      input logic [3:0] st);
      int n;
      int k;
      logic walked;
      logic s;
      logic [12:0] m;
      rxf_req_t q;
      rxf_cpl_t e;
      e = {id, w.perm, 1'h1};
      m = (w.perm[1] | ~|w.perm[3:2]) ? 13'h1FFF : 13'h1FF9;
      q = w.req;
      q.id = id;
      walked = 1'h0;
      k = 0;
      go_req <= q;
      stall <= st;
      go <= 1'h1;
      @(posedge I_CLK_SYS);
      go <= 1'h0;
      for (n = 0; n < 60; n++) begin
         @(posedge I_CLK_SYS);
         if (ep_done === 1'h1) break;
         if (O_WALK_START === 1'h1) walked = 1'h1;
         s = walked && k < w.n_ent;
         I_ENT_VALID <= s;
         I_ENT <= s ? w.ent[k] : ~I_ENT;
         if (s) k++;
      end
      tmo(n);
      cmp_w(32'(walked), 32'(w.n_ent != 2'h0));
      cmp_cpl(e, ep_cpl, m);
      zeros += (w.perm[3:2] == 2'h0);
   endtask

   always @(posedge I_CLK_SYS) begin
      if (live && !I_RESET) begin
         cmp_w(32'(O_NR_FAULT), 32'h0);
         cmp_w(32'(O_INVAL), 32'(inval_exp));
      end
      inval_exp <= I_PGFAULT_RPT;
   end

   initial begin
      I_CLK_SYS = 1'h0;
      I_RESET = 1'h1;
      {I_ENT_VALID, go, live, inval_exp} = 4'h0;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 3'h0;
      {S_AXI_ARVALID, S_AXI_RREADY, stall} = 6'h00;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
      S_AXI_WSTRB = 4'hF;
      I_ENT = '0;
      go_req = '0;
      rows[0] = mk(64'hFEEF_FFFC, 1'h0, 7'h30, 2'h0, 18'h0, 4'h6);
      rows[1] = mk(64'hFEE0_0000, 1'h1, 7'h30, 2'h0, 18'h0, 4'h6);
      rows[2] = mk(64'h8000_0000_0000, 1'h1, 7'h30, 2'h0, 18'h0, 4'h0);
      rows[3] = mk(64'hFFFF_0000_0000_0000, 1'h1, 7'h30, 2'h0, 18'h0, 4'h0);
      rows[4] = mk(64'h7FFF_FFFF_F000, 1'h1, 7'h30, 2'h3, 18'h3EF3D, 4'hC);
      rows[5] = mk(64'h80_0000_0000, 1'h0, 7'h27, 2'h0, 18'h0, 4'h0);
      rows[6] = mk(64'h7F_FFFF_F000, 1'h0, 7'h27, 2'h2, 18'h0069C, 4'h8);
      rows[7] = mk(64'h1000, 1'h1, 7'h30, 2'h2, 18'h0043D, 4'h0);
      rows[8] = mk(64'h2000, 1'h0, 7'h30, 2'h2, 18'h00598, 4'h0);
      rows[9] = mk(64'h3000, 1'h1, 7'h30, 2'h1, 18'h0002D, 4'h0);
      rows[10] = mk(64'h4000, 1'h1, 7'h30, 2'h2, 18'h00B3D, 4'h0);
      rows[11] = mk(64'h5000, 1'h0, 7'h30, 2'h1, 18'h00012, 4'h0);
      repeat (2) @(posedge I_CLK_SYS);
      I_RESET <= 1'h0;
      live <= 1'h1;
      rd_chk(A_CTRL, 32'h0000_3001, RESP_OK);
      for (i = 0; i < 12; i++) run(rows[i], 8'(i), 4'(i % 4));
      // disabled unit must leave the request waiting
      axi_wr(A_CTRL, 32'h0000_3000);
      cmp_w(32'(resp), 32'(RESP_OK));
      fork
         run(mk(64'h1_0000_0000, 1'h0, 7'h30, 2'h0, 18'h0, 4'h0), 8'h40,
             4'h1);
         begin
            repeat (8) @(posedge I_CLK_SYS);
            cmp_w(32'(I_REQ_VALID), 32'h1);
            cmp_w(32'(O_REQ_READY), 32'h0);
            axi_wr(A_CTRL, 32'h0000_2001);
         end
      join
      rd_chk(A_RCNT, 32'(zeros), RESP_OK);
      rd_chk(A_INVCNT, 32'(zeros), RESP_OK);
      rd_chk(A_STAT, 32'h0000_0008, RESP_OK);
      rd_chk(8'h10, 32'h0, RESP_ERR);
      axi_wr(A_STAT, 32'h0);
      cmp_w(32'(resp), 32'(RESP_ERR));
      @(posedge I_CLK_SYS);
      I_RESET <= 1'h1;
      repeat (2) @(posedge I_CLK_SYS);
      I_RESET <= 1'h0;
      rd_chk(A_CTRL, 32'h0000_3001, RESP_OK);
      rd_chk(A_RCNT, 32'h0, RESP_OK);
      run(rows[8], 8'h41, 4'h2);
      conclude();
   end
endmodule
